// ### src/pmec_top.sv
// Power management event control: state label, management interrupt,
// stop-clock request, idle-timer restart selection and throttle gating.
// Assumes decoded bus cycles and group masks from logic on CLK_SYS and
// raw request pins that need synchronising.
//
// Overview of operation
// - Control bits 0-1 hold the state label ON, DOZE, STANDBY, SUSPEND.
// - The state label is storage only and drives no hardware action.
// - Control bit 2 is the master enable of the management unit.
// - Writing 1 to bit 3 with unit and interrupt enabled raises an interrupt.
// - After an interrupt, no other issues until bit 3 is written 0.
// - Management interrupts issue only while control bit 4 is 1.
// - Writing 0 to bit 4 clears a pending interrupt and blocks new ones.
// - Writing 1 to bit 5 with the unit enabled starts a stop-clock.
// - Bit 6 at 0 lets master requests end the stop-clock; DMA requests never end it.
// - Bit 7 at 0 lets IRQ or NMI requests end the stop-clock.
// - Only selected activity sources restart the mode idle timer.
// - Select one bits 0-3: keyboard, display, disk ports and IRQ group.
// - Select one bits 4-7: printer, serial, floppy ports and DRQ group.
// - Select two bits 0-2: general I/O, general memory, input devices.
// - Select two bit 3 at 0 counts only unmasked DMA channels.
// - Select two bit 4 enables clock throttling.
// - Select two bits 5-7 add lines 3, 4 and 12 to input devices.
// - All three registers reset to zero and are read and write.
// - Interrupt line 1 always counts as input-device activity.
// - Throttle stop-clock releases on any management or CPU interrupt.
// - Throttling acts only while the unit master enable is set.
`timescale 1ns/100ps
`default_nettype none

module pmec_top
  import pmec_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  input wire pmec_pins_t PIN_REQ,
  input wire pmec_io_cycle_t BUS_CYCLE,
  input wire logic GENERAL_IO_RANGE_HIT,
  input wire logic GENERAL_MEM_RANGE_HIT,
  input wire logic [15:0] IRQ_GROUP_SEL,
  input wire logic [7:0] DRQ_GROUP_SEL,
  input wire logic [7:0] DMA_CHANNEL_MASK,
  input wire logic HW_SMI_EVENT,
  input wire logic CPU_INTERRUPT_REQUEST,
  input wire logic THROTTLE_PHASE,
  output logic STOP_CLOCK_REQUEST_N,
  output logic SYSTEM_MGMT_INTERRUPT,
  output logic MODE_IDLE_CLEAR,
  output logic INPUT_DEVICE_ACTIVE,
  output pmec_sys_state_t SYSTEM_STATE,
  output logic POWER_MGMT_UNIT_EN
);

  // Whole state of the block.
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] sel1;
    logic [7:0] sel2;
    pmec_pins_t sync_a;
    pmec_pins_t sync_b;
    logic lock;
    logic system_mgmt_interrupt;
    logic stop;
    logic thr_rel;
    logic stop_n;
    logic idle_clr;
    logic indev;
    logic [7:0] rdata;
  } pmec_regs_t;

  pmec_regs_t s_q;
  pmec_regs_t s_d;

  // True when the address lies inside an inclusive port range.
  function automatic logic in_range(input logic [15:0] a,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  // Decoded write strobes and the control value after this cycle.
  logic wr_ctrl;
  logic wr_sel1;
  logic wr_sel2;
  logic [7:0] nc;
  logic [7:0] ns2;
  assign wr_ctrl = REG_WR && (REG_ADDR == PMEC_OFS_CTRL);
  assign wr_sel1 = REG_WR && (REG_ADDR == PMEC_OFS_SEL1);
  assign wr_sel2 = REG_WR && (REG_ADDR == PMEC_OFS_SEL2);
  assign nc = wr_ctrl ? REG_WDATA : s_q.ctrl;
  assign ns2 = wr_sel2 ? REG_WDATA : s_q.sel2;

  // Activity sources seen on the synchronised pins and the bus.
  pmec_pins_t pin;
  logic io_ok;
  logic [7:0] act1;
  logic [2:0] act2;
  logic indev_act;
  logic [7:0] drq_ok;
  assign pin = s_q.sync_b;
  assign io_ok = BUS_CYCLE.valid && !BUS_CYCLE.mem_ab;

  // Input-device group: line 1 always, lines 3, 4, 12 when selected.
  assign indev_act = pin.irq[PMEC_IRQ_KBD]
    || (s_q.sel2[PMEC_S2_IRQ3] && pin.irq[PMEC_IRQ_3])
    || (s_q.sel2[PMEC_S2_IRQ4] && pin.irq[PMEC_IRQ_4])
    || (s_q.sel2[PMEC_S2_IRQ12] && pin.irq[PMEC_IRQ_12]);

  // DMA requests are qualified by the channel mask unless told not to.
  assign drq_ok = s_q.sel2[PMEC_S2_DRQ_ALL] ? 8'hff : ~DMA_CHANNEL_MASK;

  // Select one sources in bit order.
  always_comb begin
    act1 = 8'h00;
    act1[0] = io_ok && (BUS_CYCLE.addr == PMEC_KBD_A || BUS_CYCLE.addr == PMEC_KBD_B);
    act1[1] = BUS_CYCLE.valid && BUS_CYCLE.write
      && (BUS_CYCLE.mem_ab || in_range(BUS_CYCLE.addr, PMEC_VGA_LO, PMEC_VGA_HI));
    act1[2] = io_ok && in_range(BUS_CYCLE.addr, PMEC_HDD_LO, PMEC_HDD_HI);
    act1[3] = |(pin.irq & IRQ_GROUP_SEL);
    act1[4] = io_ok && (in_range(BUS_CYCLE.addr, PMEC_LPT1_LO, PMEC_LPT1_HI)
      || in_range(BUS_CYCLE.addr, PMEC_LPT2_LO, PMEC_LPT2_HI)
      || in_range(BUS_CYCLE.addr, PMEC_LPT3_LO, PMEC_LPT3_HI));
    act1[5] = io_ok && (in_range(BUS_CYCLE.addr, PMEC_COM1_LO, PMEC_COM1_HI)
      || in_range(BUS_CYCLE.addr, PMEC_COM2_LO, PMEC_COM2_HI)
      || in_range(BUS_CYCLE.addr, PMEC_COM3_LO, PMEC_COM3_HI)
      || in_range(BUS_CYCLE.addr, PMEC_COM4_LO, PMEC_COM4_HI));
    act1[6] = io_ok && in_range(BUS_CYCLE.addr, PMEC_FDD_LO, PMEC_FDD_HI);
    act1[7] = |(pin.drq & DRQ_GROUP_SEL & drq_ok);
  end

  // Select two sources in bit order.
  assign act2 = {indev_act, GENERAL_MEM_RANGE_HIT, GENERAL_IO_RANGE_HIT};

  // Event and release terms.
  logic pmu_on;
  logic smi_ev;
  logic sw_stop;
  logic brk;
  logic thr_on;
  assign pmu_on = nc[PMEC_C_PMU_EN];
  assign smi_ev = pmu_on && nc[PMEC_C_SMI_EN] && !s_q.lock
    && ((wr_ctrl && REG_WDATA[PMEC_C_SW_SMI]) || HW_SMI_EVENT);
  assign sw_stop = wr_ctrl && REG_WDATA[PMEC_C_STOP] && pmu_on;
  assign brk = (pin.master && !nc[PMEC_C_KEEP_MST])
    || ((|pin.irq || pin.nmi) && !nc[PMEC_C_KEEP_IRQ])
    || !nc[PMEC_C_STOP] || !pmu_on;
  assign thr_on = pmu_on && ns2[PMEC_S2_THROT] && THROTTLE_PHASE;

  // Next-state logic for the whole block.
  always_comb begin
    s_d = s_q;
    s_d.sync_a = PIN_REQ;
    s_d.sync_b = s_q.sync_a;
    // Register writes; the state label is only stored.
    if (wr_ctrl) begin
      s_d.ctrl = REG_WDATA;
    end
    if (wr_sel1) begin
      s_d.sel1 = REG_WDATA;
    end
    if (wr_sel2) begin
      s_d.sel2 = REG_WDATA;
    end
    // Lockout set by an issued event wins over the clearing write.
    s_d.lock = smi_ev || (s_q.lock && !(wr_ctrl && !REG_WDATA[PMEC_C_SW_SMI]));
    // Pending interrupt drops when its enable is written to zero.
    s_d.system_mgmt_interrupt = smi_ev || (s_q.system_mgmt_interrupt && nc[PMEC_C_SMI_EN]);
    // Software stop-clock holds until a break condition.
    s_d.stop = sw_stop || (s_q.stop && !brk);
    // Throttle release stands for the rest of the stop phase.
    s_d.thr_rel = thr_on && (s_q.thr_rel || smi_ev || CPU_INTERRUPT_REQUEST);
    s_d.stop_n = !(s_d.stop || (thr_on && !s_d.thr_rel));
    // Idle timer restart from selected sources only.
    s_d.idle_clr = |(act1 & s_q.sel1) || |(act2 & s_q.sel2[2:0]);
    s_d.indev = indev_act;
    // Read data stand for one cycle after the strobe.
    s_d.rdata = PMEC_RD_NONE;
    if (REG_RD) begin
      unique case (REG_ADDR)
        PMEC_OFS_CTRL: s_d.rdata = s_q.ctrl;
        PMEC_OFS_SEL1: s_d.rdata = s_q.sel1;
        PMEC_OFS_SEL2: s_d.rdata = s_q.sel2;
        default: s_d.rdata = PMEC_RD_NONE;
      endcase
    end
  end

  // State register with synchronous reset.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      s_q.ctrl <= PMEC_REG_RST;
      s_q.sel1 <= PMEC_REG_RST;
      s_q.sel2 <= PMEC_REG_RST;
      s_q.sync_a <= '0;
      s_q.sync_b <= '0;
      s_q.lock <= 1'h0;
      s_q.system_mgmt_interrupt <= 1'h0;
      s_q.stop <= 1'h0;
      s_q.thr_rel <= 1'h0;
      s_q.stop_n <= 1'h1;
      s_q.idle_clr <= 1'h0;
      s_q.indev <= 1'h0;
      s_q.rdata <= PMEC_RD_NONE;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs come straight from the state flip-flops.
  assign REG_RDATA = s_q.rdata;
  assign STOP_CLOCK_REQUEST_N = s_q.stop_n;
  assign SYSTEM_MGMT_INTERRUPT = s_q.system_mgmt_interrupt;
  assign MODE_IDLE_CLEAR = s_q.idle_clr;
  assign INPUT_DEVICE_ACTIVE = s_q.indev;
  assign SYSTEM_STATE = pmec_sys_state_t'(s_q.ctrl[PMEC_C_STATE_HI:PMEC_C_STATE_LO]);
  assign POWER_MGMT_UNIT_EN = s_q.ctrl[PMEC_C_PMU_EN];

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  // Read data are zero except right after a read strobe.
  chk_rdata_idle: assert property (
    !$past(REG_RD) |-> REG_RDATA == PMEC_RD_NONE
  ) else $error("read data not zero outside read answer");

  // A control write reads back on the following read.
  chk_ctrl_readback: assert property (
    wr_ctrl ##1 (REG_RD && REG_ADDR == PMEC_OFS_CTRL && !REG_WR)
      |=> REG_RDATA == $past(REG_WDATA, 2)
  ) else $error("control register read back mismatch");

  // The interrupt output never stands without its enable.
  chk_smi_gate: assert property (
    SYSTEM_MGMT_INTERRUPT |-> s_q.ctrl[PMEC_C_SMI_EN]
  ) else $error("interrupt raised while disabled");

  // Clearing the enable drops the interrupt at the next edge.
  chk_smi_clear: assert property (
    wr_ctrl && !REG_WDATA[PMEC_C_SMI_EN] |=> !SYSTEM_MGMT_INTERRUPT
  ) else $error("interrupt not cleared by enable write");

  // Software interrupt write raises the output one cycle later.
  chk_sw_smi: assert property (
    wr_ctrl && REG_WDATA[PMEC_C_SW_SMI] && REG_WDATA[PMEC_C_SMI_EN]
      && REG_WDATA[PMEC_C_PMU_EN] && !s_q.lock
      |=> SYSTEM_MGMT_INTERRUPT && s_q.lock
  ) else $error("software interrupt not raised");

  // While locked no new interrupt rises.
  chk_smi_lock: assert property (
    s_q.lock && !wr_ctrl && !SYSTEM_MGMT_INTERRUPT |=> !SYSTEM_MGMT_INTERRUPT
  ) else $error("interrupt raised during lockout");

  // A software stop request drives the active-low output.
  chk_stop_start: assert property (
    sw_stop |=> !STOP_CLOCK_REQUEST_N && s_q.stop
  ) else $error("stop-clock not started");

  // A master request breaks the stop-clock unless kept.
  chk_master_break: assert property (
    s_q.stop && !wr_ctrl && pin.master && !s_q.ctrl[PMEC_C_KEEP_MST]
      |=> !s_q.stop
  ) else $error("master request did not break stop-clock");

  // With both keep bits set, requests leave the stop-clock alone.
  chk_irq_keep: assert property (
    s_q.stop && !wr_ctrl && s_q.ctrl[PMEC_C_KEEP_IRQ]
      && s_q.ctrl[PMEC_C_KEEP_MST] && s_q.ctrl[PMEC_C_PMU_EN]
      && s_q.ctrl[PMEC_C_STOP] |=> s_q.stop [*1] ##0 !STOP_CLOCK_REQUEST_N
  ) else $error("stop-clock broken while kept");

  // Nothing selected means no idle restart.
  chk_idle_unsel: assert property (
    s_q.sel1 == 8'h00 && s_q.sel2[2:0] == 3'h0 |=> !MODE_IDLE_CLEAR
  ) else $error("idle restart from unselected source");

  // Line 1 always counts as input-device activity.
  chk_indev_line1: assert property (
    pin.irq[PMEC_IRQ_KBD] |=> INPUT_DEVICE_ACTIVE
  ) else $error("line 1 not seen as input-device activity");

  // Without the master enable the output stays released.
  chk_thr_pmu: assert property (
    !s_q.ctrl[PMEC_C_PMU_EN] && !wr_ctrl |=> STOP_CLOCK_REQUEST_N
  ) else $error("stop-clock active with unit disabled");

  // An interrupt or NMI request breaks the stop-clock unless kept.
  chk_irq_break: assert property (
    s_q.stop && !wr_ctrl && (|pin.irq || pin.nmi) && !s_q.ctrl[PMEC_C_KEEP_IRQ]
      |=> !s_q.stop
  ) else $error("interrupt request did not break stop-clock");

  // A processor interrupt during a throttle phase lifts the throttle stop.
  chk_thr_release: assert property (
    thr_on && CPU_INTERRUPT_REQUEST |=> STOP_CLOCK_REQUEST_N == !s_q.stop
  ) else $error("throttle stop not released by interrupt");

  // The state label follows the written control value.
  chk_state_label: assert property (
    wr_ctrl |=> SYSTEM_STATE == $past(REG_WDATA[PMEC_C_STATE_HI:PMEC_C_STATE_LO])
  ) else $error("state label not taken from control write");

  // A selected general I/O hit restarts the idle timer.
  chk_idle_select: assert property (
    GENERAL_IO_RANGE_HIT && s_q.sel2[PMEC_S2_GPIO] |=> MODE_IDLE_CLEAR
  ) else $error("selected source did not restart idle timer");

  // With the unit disabled no interrupt rises.
  chk_unit_smi_off: assert property (
    !s_q.ctrl[PMEC_C_PMU_EN] && !wr_ctrl && !SYSTEM_MGMT_INTERRUPT
      |=> !SYSTEM_MGMT_INTERRUPT
  ) else $error("interrupt raised with unit disabled");

endmodule : pmec_top

`default_nettype wire

// ### src/pmec_pkg.sv
// Constants and types shared by the power management event control block.
// Assumes an 8-bit register port and decoded bus activity from the chipset core.
package pmec_pkg;

  // Register offsets on the local register port.
  localparam logic [7:0] PMEC_OFS_CTRL = 8'h30;
  localparam logic [7:0] PMEC_OFS_SEL1 = 8'h31;
  localparam logic [7:0] PMEC_OFS_SEL2 = 8'h32;
  localparam logic [7:0] PMEC_REG_RST = 8'h00;
  localparam logic [7:0] PMEC_RD_NONE = 8'h00;

  // Control register fields.
  localparam int unsigned PMEC_C_STATE_LO = 0;
  localparam int unsigned PMEC_C_STATE_HI = 1;
  localparam int unsigned PMEC_C_PMU_EN = 2;
  localparam int unsigned PMEC_C_SW_SMI = 3;
  localparam int unsigned PMEC_C_SMI_EN = 4;
  localparam int unsigned PMEC_C_STOP = 5;
  localparam int unsigned PMEC_C_KEEP_MST = 6;
  localparam int unsigned PMEC_C_KEEP_IRQ = 7;

  // Select register two fields; register one uses bits 0 to 7 in order.
  localparam int unsigned PMEC_S2_GPIO = 0;
  localparam int unsigned PMEC_S2_GPMEM = 1;
  localparam int unsigned PMEC_S2_INDEV = 2;
  localparam int unsigned PMEC_S2_DRQ_ALL = 3;
  localparam int unsigned PMEC_S2_THROT = 4;
  localparam int unsigned PMEC_S2_IRQ3 = 5;
  localparam int unsigned PMEC_S2_IRQ4 = 6;
  localparam int unsigned PMEC_S2_IRQ12 = 7;

  // Interrupt line numbers of the input-device group.
  localparam int unsigned PMEC_IRQ_KBD = 1;
  localparam int unsigned PMEC_IRQ_3 = 3;
  localparam int unsigned PMEC_IRQ_4 = 4;
  localparam int unsigned PMEC_IRQ_12 = 12;

  // Watched I/O port ranges.
  localparam logic [15:0] PMEC_KBD_A = 16'h0060;
  localparam logic [15:0] PMEC_KBD_B = 16'h0064;
  localparam logic [15:0] PMEC_VGA_LO = 16'h03b0;
  localparam logic [15:0] PMEC_VGA_HI = 16'h03bf;
  localparam logic [15:0] PMEC_HDD_LO = 16'h01f0;
  localparam logic [15:0] PMEC_HDD_HI = 16'h01f7;
  localparam logic [15:0] PMEC_LPT1_LO = 16'h0378;
  localparam logic [15:0] PMEC_LPT1_HI = 16'h037f;
  localparam logic [15:0] PMEC_LPT2_LO = 16'h0278;
  localparam logic [15:0] PMEC_LPT2_HI = 16'h027f;
  localparam logic [15:0] PMEC_LPT3_LO = 16'h03bc;
  localparam logic [15:0] PMEC_LPT3_HI = 16'h03be;
  localparam logic [15:0] PMEC_COM1_LO = 16'h03f8;
  localparam logic [15:0] PMEC_COM1_HI = 16'h03ff;
  localparam logic [15:0] PMEC_COM2_LO = 16'h02f8;
  localparam logic [15:0] PMEC_COM2_HI = 16'h02ff;
  localparam logic [15:0] PMEC_COM3_LO = 16'h03e8;
  localparam logic [15:0] PMEC_COM3_HI = 16'h03ef;
  localparam logic [15:0] PMEC_COM4_LO = 16'h02e8;
  localparam logic [15:0] PMEC_COM4_HI = 16'h02ee;
  localparam logic [15:0] PMEC_FDD_LO = 16'h03f0;
  localparam logic [15:0] PMEC_FDD_HI = 16'h03f7;

  // Software label of the system power state.
  typedef enum logic [1:0] {
    PMEC_ST_ON = 2'b00,
    PMEC_ST_DOZE = 2'b01,
    PMEC_ST_STANDBY = 2'b10,
    PMEC_ST_SUSPEND = 2'b11
  } pmec_sys_state_t;

  // Request pins that arrive from outside the clock domain.
  typedef struct packed {
    logic [15:0] irq;
    logic nmi;
    logic [7:0] drq;
    logic master;
  } pmec_pins_t;

  // One decoded bus cycle from the core, valid for one clock.
  typedef struct packed {
    logic valid;
    logic write;
    logic mem_ab;
    logic [15:0] addr;
  } pmec_io_cycle_t;

endpackage : pmec_pkg

// ### verification/pmec_cpu_model.sv
// Behavioural host processor facing the stop-clock and interrupt outputs.
// Assumes the clock and reset of the block; its outputs feed the bench only.
`timescale 1ns/100ps
`default_nettype none
module pmec_cpu_model
  import pmec_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic STOP_CLOCK_REQUEST_N,
  input wire logic SYSTEM_MGMT_INTERRUPT,
  output var logic halted,
  output var logic [7:0] smi_cnt
);
  logic smi_q;
  // Halts while stop-clock is low, resumes once it rises, and counts entries.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      halted <= 1'b0;
      smi_cnt <= 8'h00;
      smi_q <= 1'b0;
    end else begin
      halted <= !STOP_CLOCK_REQUEST_N;
      smi_q <= SYSTEM_MGMT_INTERRUPT;
      if (SYSTEM_MGMT_INTERRUPT && !smi_q) begin
        smi_cnt <= smi_cnt + 8'h01;
      end
    end
  end
endmodule : pmec_cpu_model
`default_nettype wire

// ### verification/testbench.sv
// Self-checking bench of the power management event control block.
// Assumes the package and the processor model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import pmec_pkg::*;
  localparam logic [7:0] CT = PMEC_OFS_CTRL;
  localparam logic [7:0] S1 = PMEC_OFS_SEL1;
  localparam logic [7:0] S2 = PMEC_OFS_SEL2;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  pmec_pins_t pins = '0;
  pmec_io_cycle_t bus = '0;
  logic general_io_range = 1'b0;
  logic general_mem_range = 1'b0;
  logic [15:0] irq_sel = 16'h0100;
  logic [7:0] drq_sel = 8'h03;
  logic [7:0] dma_mask = 8'h01;
  logic hw_smi = 1'b0;
  logic cpu_int = 1'b0;
  logic thr = 1'b0;
  logic [7:0] rdata;
  logic [7:0] smi_cnt;
  logic stop_n, system_mgmt_interrupt, idle_clr, indev, pmu_en, halted;
  pmec_sys_state_t state;
  int fails = 0;
  int n_checks = 0;
  logic [15:0] ad [7] = '{16'h0064, 16'h03b0, 16'h01f7, 16'h0000, 16'h027f, 16'h02ee, 16'h03f0};

  pmec_top i_pmec_top (.CLK_SYS(clk_sys), .RST(rst), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(rdata),
    .PIN_REQ(pins), .BUS_CYCLE(bus), .GENERAL_IO_RANGE_HIT(general_io_range), .GENERAL_MEM_RANGE_HIT(general_mem_range),
    .IRQ_GROUP_SEL(irq_sel), .DRQ_GROUP_SEL(drq_sel), .DMA_CHANNEL_MASK(dma_mask),
    .HW_SMI_EVENT(hw_smi), .CPU_INTERRUPT_REQUEST(cpu_int), .THROTTLE_PHASE(thr),
    .STOP_CLOCK_REQUEST_N(stop_n), .SYSTEM_MGMT_INTERRUPT(system_mgmt_interrupt),
    .MODE_IDLE_CLEAR(idle_clr), .INPUT_DEVICE_ACTIVE(indev),
    .SYSTEM_STATE(state), .POWER_MGMT_UNIT_EN(pmu_en));
  pmec_cpu_model i_pmec_cpu_model (.CLK_SYS(clk_sys), .RST(rst),
    .STOP_CLOCK_REQUEST_N(stop_n), .SYSTEM_MGMT_INTERRUPT(system_mgmt_interrupt),
    .halted(halted), .smi_cnt(smi_cnt));

  // Clock of 25 ns period.
  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end

  // Prints the counts and the verdict, then stops the run.
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim

  // Compares one value and reports a mismatch at once.
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Waits some edges, then lets their updates settle.
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  // One write cycle on the register port.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  // One read cycle; the data are judged in the following cycle.
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk("read data", exp, rdata);
  endtask : rd

  // A write and, with no gap, a read of the same place.
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk("read after write", d, rdata);
  endtask : wr_rd

  // Pulses the other interrupt source for one cycle.
  task automatic hw_pulse();
    @(posedge clk_sys);
    hw_smi <= 1'b1;
    @(posedge clk_sys);
    hw_smi <= 1'b0;
    tick(1);
  endtask : hw_pulse

  // Reset values, read-back, unmapped place and the state label.
  task automatic t_regs();
    rd(CT, 8'h00);
    rd(S1, 8'h00);
    rd(S2, 8'h00);
    wr(S1, 8'h5a);
    wr(S2, 8'ha5);
    wr(8'h40, 8'hff);
    rd(S1, 8'h5a);
    rd(S2, 8'ha5);
    rd(8'h40, 8'h00);
    for (int s = 0; s < 4; s++) begin
      wr(CT, 8'(s));
      chk("state label", 8'(s), 8'(state));
      rd(CT, 8'(s));
      chk("stop idle", 8'h01, 8'(stop_n));
    end
    wr_rd(CT, 8'hc3);
    wr(S1, 8'h00);
    wr(S2, 8'h00);
    wr(CT, 8'h00);
  endtask : t_regs

  // Software and other interrupts with enable, lockout and clear.
  task automatic t_smi();
    wr(CT, 8'h18);
    tick(1);
    chk("smi unit off", 8'h00, 8'(system_mgmt_interrupt));
    wr(CT, 8'h1c);
    tick(1);
    chk("smi soft", 8'h01, 8'(system_mgmt_interrupt));
    chk("unit enable", 8'h01, 8'(pmu_en));
    wr(CT, 8'h0c);
    tick(1);
    chk("smi cleared", 8'h00, 8'(system_mgmt_interrupt));
    wr(CT, 8'h1c);
    tick(1);
    chk("smi locked", 8'h00, 8'(system_mgmt_interrupt));
    hw_pulse();
    chk("smi hw locked", 8'h00, 8'(system_mgmt_interrupt));
    wr(CT, 8'h14);
    hw_pulse();
    chk("smi hw", 8'h01, 8'(system_mgmt_interrupt));
    wr(CT, 8'h04);
    tick(1);
    chk("smi off", 8'h00, 8'(system_mgmt_interrupt));
    hw_pulse();
    chk("smi blocked", 8'h00, 8'(system_mgmt_interrupt));
    chk("smi entries", 8'h02, smi_cnt);
  endtask : t_smi

  // Starts a stop-clock, raises one break source and judges the outcome.
  task automatic brk(input logic [7:0] c, input logic m, input logic e);
    wr(CT, c);
    tick(1);
    chk("stop set", 8'h00, 8'(stop_n));
    chk("cpu halted", 8'h01, 8'(halted));
    @(posedge clk_sys);
    pins <= '{irq: (m ? 16'h0000 : 16'h0020), nmi: 1'b0, drq: 8'h00, master: m};
    tick(5);
    chk("stop break", 8'(e), 8'(stop_n));
    @(posedge clk_sys);
    pins <= '0;
    tick(4);
    chk("stop after", 8'(e), 8'(stop_n));
    wr(CT, 8'h04);
    tick(1);
    chk("stop cleared", 8'h01, 8'(stop_n));
    chk("cpu resumed", 8'h00, 8'(halted));
  endtask : brk

  // Stop-clock refusal and the four break settings.
  task automatic t_stop();
    wr(CT, 8'h20);
    tick(1);
    chk("stop unit off", 8'h01, 8'(stop_n));
    brk(8'h24, 1'b1, 1'b1);
    brk(8'h64, 1'b1, 1'b0);
    brk(8'h24, 1'b0, 1'b1);
    brk(8'ha4, 1'b0, 1'b0);
    brk(8'he4, 1'b1, 1'b0);
  endtask : t_stop

  // Throttling, its release by a processor interrupt and its gating.
  task automatic t_thr();
    wr(S2, 8'h10);
    @(posedge clk_sys);
    thr <= 1'b1;
    tick(3);
    chk("throttle", 8'h00, 8'(stop_n));
    @(posedge clk_sys);
    cpu_int <= 1'b1;
    tick(3);
    chk("throttle release", 8'h01, 8'(stop_n));
    @(posedge clk_sys);
    cpu_int <= 1'b0;
    thr <= 1'b0;
    wr(CT, 8'h00);
    @(posedge clk_sys);
    thr <= 1'b1;
    tick(3);
    chk("throttle gated", 8'h01, 8'(stop_n));
    @(posedge clk_sys);
    thr <= 1'b0;
  endtask : t_thr

  // One decoded port or memory write under a given first select value.
  task automatic io(input logic [15:0] a, input logic m, input logic [7:0] s, input logic e);
    wr(S1, s);
    @(posedge clk_sys);
    bus <= '{valid: 1'b1, write: 1'b1, mem_ab: m, addr: a};
    @(posedge clk_sys);
    bus <= '0;
    #1;
    chk("idle port", 8'(e), 8'(idle_clr));
  endtask : io

  // Held pin and range levels under given select values.
  task automatic pidl(input logic [15:0] i, input logic [7:0] d, input logic [1:0] g,
                      input logic [7:0] s1, input logic [7:0] s2, input logic ec,
                      input logic ei);
    wr(S1, s1);
    wr(S2, s2);
    @(posedge clk_sys);
    pins <= '{irq: i, nmi: 1'b0, drq: d, master: 1'b0};
    general_io_range <= g[0];
    general_mem_range <= g[1];
    tick(4);
    chk("idle level", 8'(ec), 8'(idle_clr));
    chk("input device", 8'(ei), 8'(indev));
    @(posedge clk_sys);
    pins <= '0;
    general_io_range <= 1'b0;
    general_mem_range <= 1'b0;
    tick(4);
  endtask : pidl

  // One port of each port select bit selected alone and then left out.
  task automatic t_idle();
    for (int b = 0; b < 7; b++) begin
      if (b != 3) begin
        io(ad[b], 1'b0, 8'h01 << b, 1'b1);
        io(ad[b], 1'b0, ~(8'h01 << b), 1'b0);
      end
    end
    io(16'h0000, 1'b1, 8'h02, 1'b1);
    io(16'h0000, 1'b1, 8'hfd, 1'b0);
    pidl(16'h0002, 8'h00, 2'b00, 8'h00, 8'h00, 1'b0, 1'b1);
    pidl(16'h0002, 8'h00, 2'b00, 8'h00, 8'h04, 1'b1, 1'b1);
    pidl(16'h0008, 8'h00, 2'b00, 8'h00, 8'h00, 1'b0, 1'b0);
    pidl(16'h0008, 8'h00, 2'b00, 8'h00, 8'h20, 1'b0, 1'b1);
    pidl(16'h0010, 8'h00, 2'b00, 8'h00, 8'h40, 1'b0, 1'b1);
    pidl(16'h1000, 8'h00, 2'b00, 8'h00, 8'h80, 1'b0, 1'b1);
    pidl(16'h0100, 8'h00, 2'b00, 8'h08, 8'h00, 1'b1, 1'b0);
    pidl(16'h0000, 8'h01, 2'b00, 8'h80, 8'h00, 1'b0, 1'b0);
    pidl(16'h0000, 8'h01, 2'b00, 8'h80, 8'h08, 1'b1, 1'b0);
    pidl(16'h0000, 8'h02, 2'b00, 8'h80, 8'h00, 1'b1, 1'b0);
    pidl(16'h0000, 8'h00, 2'b01, 8'h00, 8'h01, 1'b1, 1'b0);
    pidl(16'h0000, 8'h00, 2'b10, 8'h00, 8'h02, 1'b1, 1'b0);
    pidl(16'h0000, 8'h00, 2'b01, 8'h00, 8'h02, 1'b0, 1'b0);
  endtask : t_idle

  // Main sequence after twelve cycles of reset.
  initial begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    t_regs();
    t_smi();
    t_stop();
    t_thr();
    t_idle();
    end_sim();
  end

  // Cuts a hang short well beyond the expected run length.
  initial begin
    repeat (5000) @(posedge clk_sys);
    fails++;
    end_sim();
  end
endmodule : testbench
`default_nettype wire
